// ===== rtl/twi_pkg.sv
/*
  Constants shared by the two-wire serial engine: control bit positions,
  reset values, sequencer states and divider figures.
  Assumes a single 20 MHz clock mclk; the divider steps once per mclk.
*/
package twi_pkg;
  // ==========================================================
  // control register 2 bit positions
  localparam int START_BIT   = 0;
  localparam int RSTART_BIT  = 1;
  localparam int STOP_BIT    = 2;
  localparam int RECV_BIT    = 3;
  localparam int ACKSEND_BIT = 4;
  localparam int ACKDATA_BIT = 5;
  localparam int ACKSTAT_BIT = 6;
  localparam int GENERAL_CALL_ENABLE_BIT    = 7;
  // status bits
  localparam int UA_BIT      = 1;
  localparam int BF_BIT      = 0;
  // ==========================================================
  // mode select codes
  localparam logic [3:0] MODE_MASTER  = 4'h8;
  localparam logic [3:0] MODE_SLAVE7  = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  // ==========================================================
  // reset values and fixed values
  localparam logic [7:0] GCALL_ADDR   = 8'h00;
  localparam logic [6:0] RELOAD_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ==========================================================
  // fifo
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // master sequencer states, one-hot
  typedef enum logic [8:0] {
    M_IDLE  = 9'h001,
    M_START = 9'h002,
    M_RST   = 9'h004,
    M_STOP  = 9'h008,
    M_TX    = 9'h010,
    M_RX    = 9'h020,
    M_ACK   = 9'h040,
    M_HOLD  = 9'h080,
    M_WAIT  = 9'h100
  } mstate_type;
endpackage

// ===== rtl/twi_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module twi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // ==========================================================
  // pointer and storage next values
  always_comb
  begin
    push    = inValid && inReady;
    pop     = outValid && outReady;
    mem_d   = mem_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    if (push)
    begin
      mem_d[wr_q] = inData;
      wr_d = wr_q + 1'b1;
    end
    if (pop)
      rd_d = rd_q + 1'b1;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // honest full and empty
  assign inReady  = (cnt_q != (AW+1)'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData  = mem_q[rd_q];

  // register only
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule // twi_fifo
`default_nettype wire

// ===== rtl/twi_engine.sv
/*
  Two-wire serial engine: master sequencer with reload divider and
  clock arbitration, slave address and general call recognition,
  clock hold through clock_release. Transmit bytes arrive through a
  16-word FIFO. Assumes mclk 20 MHz, inputs synchronous to mclk,
  bus line levels resolved outside from the enables.
*/
// Notes on behaviour
// (RULE1) clearing clock release holds clock only after line already sampled low
// (RULE2) held clock stays low until release set and line seen high; here it is let go as soon as release is set
// (RULE3) all-zero address with write bit is the general call
// (RULE4) received address compared with own address and general call if enabled
// (RULE5) general call copies shift to receive buffer, buffer full, flag on ninth; here flag on falling edge of the eighth clock
// (RULE6) ten-bit normal address sets update flag; general call skips it
// (RULE7) master runs only when master mode selected and enabled, pins as inputs
// (RULE8) start and stop seen clear on reset or disable; claim when idle
// (RULE9) buffer write during a start is dropped and sets write collision
// (RULE10) interrupt flag on start, stop, byte, acknowledge sent, repeated start
// (RULE11) transfer ends with stop or repeated start without releasing bus
// (RULE12) software loads address with read/write bit, then 8-bit bytes
// (RULE13) receiving master sends acknowledge; transmitting master takes one
// (RULE14) slave acknowledge stored in acknowledge status, flag after ninth clock
// (RULE15) start enable generates start, waits, then flags completion
// (RULE16) stop enable generates stop and flags once complete
// (RULE17) divider reload is the low 7 bits of the address register
// (RULE18) buffer write starts divider; counts to zero, stops, reloads automatically
// (RULE19) divider steps twice per instruction cycle, once per mclk here
// (RULE20) after acknowledge the divider stops and clock keeps last state
// (RULE21) software never programs a reload of zero
// (RULE22) one clock period is two divider rollovers
// (RULE23) released clock pauses divider until sampled high, then reloads
// (RULE24) write collision stays set until software clears it
// (RULE25) reset or disable idles sequencer, stops divider, releases lines
`timescale 1ns/1ps
`default_nettype none
module twi_engine (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // configuration
  input  wire logic                 moduleEnable,
  input  wire logic [3:0]           modeSelect,
  input  wire logic                 pinDirSclIn,
  input  wire logic                 pinDirSdaIn,
  input  wire logic [7:0]           addressReload,
  input  wire logic                 generalCallEnable,
  input  wire logic                 clockRelease,
  input  wire logic                 ackData,
  // one-cycle commands
  input  wire logic                 startEnable,
  input  wire logic                 rstartEnable,
  input  wire logic                 stopEnable,
  input  wire logic                 recvEnable,
  input  wire logic                 ackEnable,
  input  wire logic                 intClear,
  input  wire logic                 wcolClear,
  input  wire logic                 rxRead,
  // transmit byte stream
  input  wire logic                 txValid,
  output logic                      txReady,
  input  wire logic [7:0]           txData,
  // status
  output logic [7:0]                rxBuffer,
  output logic                      bufferFull,
  output logic                      ackStatus,
  output logic                      serialIntFlag,
  output logic                      writeCollision,
  output logic                      updateAddress,
  output logic                      generalCallHit,
  output logic                      startSeen,
  output logic                      stopSeen,
  output logic                      busyStart,
  // bus lines
  input  wire logic                 sclIn,
  output logic                      sclOut,
  output logic                      sclOe,
  input  wire logic                 sdaIn,
  output logic                      sdaOut,
  output logic                      sdaOe
);
  import twi_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic gcMatch(input logic [7:0] b, input logic en);
    gcMatch = en && (b == GCALL_ADDR);
  endfunction

  logic       active;
  logic       fifoValid, fifoReady;
  logic [7:0] fifoData;

  // ==========================================================
  // transmit fifo; stalls the source when full
  twi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) txFifo (
    .mclk     (mclk),
    .rstn     (rstn),
    .inValid  (txValid && !busyStart), // (RULE9) write dropped during start
    .inReady  (txReady),
    .inData   (txData),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData)
  );

  // (RULE7) master gating
  assign active = moduleEnable && (modeSelect == MODE_MASTER) && pinDirSclIn && pinDirSdaIn;

  // ==========================================================
  // master state
  mstate_type st_q, st_d;
  logic [6:0] brg_q, brg_d;
  logic       brgRun_q, brgRun_d;
  logic       phase_q, phase_d;       // 0 = low half, 1 = high half
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] step_q, step_d;
  logic       sclLow_q, sclLow_d;     // drive scl low
  logic       sdaLow_q, sdaLow_d;     // drive sda low
  logic       rel_q, rel_d;           // scl release awaits high sample
  logic       brgZero, brgTick, lastBit;

  assign brgZero = (brg_q == 7'h00);
  // (RULE19) one step per mclk equals Q2 and Q4 rate
  assign brgTick = brgRun_q && brgZero;
  // receive ends after eight clocks, transmit after the ninth
  assign lastBit = (st_q == M_RX) ? (bit_q == BITS_PER_BYTE - 4'h1) : (bit_q == BITS_PER_BYTE);

  always_comb
  begin
    st_d     = st_q;
    brg_d    = brg_q;
    brgRun_d = brgRun_q;
    phase_d  = phase_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    step_d   = step_q;
    sclLow_d = sclLow_q;
    sdaLow_d = sdaLow_q;
    rel_d    = rel_q;
    fifoReady = 1'b0;
    // (RULE18) count down to zero then stop
    if (brgRun_q && !brgZero)
      brg_d = brg_q - 7'h01;
    // (RULE23) paused until scl seen high, then reload
    if (rel_q && sclIn)
    begin
      rel_d    = 1'b0;
      // (RULE17) low 7 bits reload
      brg_d    = addressReload[6:0];
      brgRun_d = 1'b1;
    end
    case (st_q)
      M_IDLE:
      begin
        step_d = 2'd0;
        // (RULE15) start enable
        if (startEnable && sclIn && sdaIn)
        begin
          st_d = M_START;
          brg_d = addressReload[6:0];
          brgRun_d = 1'b1;
        end
      end
      M_HOLD:
      begin
        // (RULE18) buffer write starts divider
        if (fifoValid)
        begin
          fifoReady = 1'b1;
          sh_d   = fifoData;
          bit_d  = 4'h0;
          phase_d = 1'b0;
          st_d   = M_TX;
          sdaLow_d = !fifoData[7];
          brg_d  = addressReload[6:0];
          brgRun_d = 1'b1;
        end
        else if (recvEnable)
        begin
          bit_d  = 4'h0;
          phase_d = 1'b0;
          sdaLow_d = 1'b0;
          st_d   = M_RX;
          brg_d  = addressReload[6:0];
          brgRun_d = 1'b1;
        end
        else if (ackEnable)
        begin
          // (RULE13) receiving master sends acknowledge
          sdaLow_d = !ackData;
          phase_d = 1'b0;
          st_d   = M_ACK;
          brg_d  = addressReload[6:0];
          brgRun_d = 1'b1;
        end
        // (RULE11) (RULE16) stop or repeated start
        else if (stopEnable)
        begin
          sdaLow_d = 1'b1;
          step_d = 2'd0;
          st_d   = M_STOP;
          brg_d  = addressReload[6:0];
          brgRun_d = 1'b1;
        end
        else if (rstartEnable)
        begin
          sdaLow_d = 1'b0;
          step_d = 2'd0;
          st_d   = M_RST;
          brg_d  = addressReload[6:0];
          brgRun_d = 1'b1;
        end
      end
      M_START:
        if (brgTick)
        begin
          if (step_q == 2'd0)
          begin
            sdaLow_d = 1'b1;
            step_d = 2'd1;
            brg_d  = addressReload[6:0];
          end
          else
          begin
            sclLow_d = 1'b1;
            brgRun_d = 1'b0;
            st_d   = M_HOLD;
          end
        end
      M_RST, M_STOP:
        if (brgTick)
        begin
          // (RULE11) bus stays claimed through repeated start
          if (step_q == 2'd0)
          begin
            sclLow_d = 1'b0;
            rel_d  = 1'b1;
            brgRun_d = 1'b0;
            step_d = 2'd1;
          end
          else if (step_q == 2'd1)
          begin
            sdaLow_d = (st_q == M_RST);
            brg_d  = addressReload[6:0];
            step_d = 2'd2;
          end
          else
          begin
            brgRun_d = 1'b0;
            sclLow_d = (st_q == M_RST);
            st_d   = (st_q == M_RST) ? M_HOLD : M_IDLE;
          end
        end
      M_TX, M_RX, M_ACK:
        if (brgTick)
        begin
          if (!phase_q)
          begin
            // (RULE22) low half is one rollover
            sclLow_d = 1'b0;
            rel_d  = 1'b1;
            brgRun_d = 1'b0;
            phase_d = 1'b1;
          end
          else
          begin
            // falling edge ends the high half
            sclLow_d = 1'b1;
            phase_d = 1'b0;
            brg_d  = addressReload[6:0];
            if (st_q == M_ACK)
            begin
              // (RULE20) stop divider after acknowledge
              brgRun_d = 1'b0;
              st_d   = M_HOLD;
            end
            else if (lastBit)
            begin
              // (RULE14) last clock ends the byte: ninth for transmit, eighth for receive
              brgRun_d = 1'b0;
              st_d   = M_HOLD;
              sdaLow_d = 1'b0;
            end
            else
            begin
              bit_d = bit_q + 4'h1;
              if (st_q == M_TX)
              begin
                sh_d = {sh_q[6:0], 1'b0};
                sdaLow_d = (bit_q + 4'h1 == BITS_PER_BYTE) ? 1'b0 : !sh_q[6];
              end
            end
          end
        end
      M_WAIT:
        st_d = M_IDLE;
      default:
        st_d = M_IDLE;
    endcase
    // (RULE25) disable idles sequencer, stops divider, drops line drives
    if (!active)
    begin
      st_d = M_IDLE;
      brgRun_d = 1'b0;
      sclLow_d = 1'b0;
      sdaLow_d = 1'b0;
      rel_d = 1'b0;
    end
  end

  // ==========================================================
  // flags: set wins over intClear, wcolClear and rxRead
  logic       sif_q, sif_d, write_collision_flag_q, write_collision_flag_d, ack_q, ack_d;
  logic       bf_q, bf_d, ua_q, ua_d, gc_q, gc_d, ss_q, ss_d, ps_q, ps_d;
  logic [7:0] rx_q, rx_d;
  logic       sclPrev_q, sdaPrev_q, sclEdgeUp, sclEdgeDn;
  logic       hold_q, hold_d;
  logic [3:0] sbit_q, sbit_d;
  logic [7:0] ssh_q, ssh_d;
  logic       addrPhase_q, addrPhase_d;

  // update flag clears when software changes the address
  logic [7:0] addrSeen_q;
  function automatic logic updateAddressPending();
    updateAddressPending = (addrSeen_q == addressReload);
  endfunction

  assign sclEdgeUp = sclIn && !sclPrev_q;
  assign sclEdgeDn = !sclIn && sclPrev_q;

  always_comb
  begin
    sif_d = sif_q && !intClear;
    // (RULE24) collision sticky until cleared
    write_collision_flag_d = write_collision_flag_q && !wcolClear;
    ack_d = ack_q;
    bf_d  = bf_q && !rxRead;
    ua_d  = ua_q;
    gc_d  = gc_q;
    ss_d  = ss_q;
    ps_d  = ps_q;
    rx_d  = rx_q;
    hold_d = hold_q;
    sbit_d = sbit_q;
    ssh_d = ssh_q;
    addrPhase_d = addrPhase_q;
    // (RULE9) write during start is refused
    if (txValid && (st_q == M_START || st_q == M_RST))
      write_collision_flag_d = 1'b1;
    // (RULE10) completion events
    if (brgTick && ((st_q == M_START && step_q == 2'd1) ||
        (st_q == M_RST && step_q == 2'd2) || (st_q == M_STOP && step_q == 2'd2)))
      sif_d = 1'b1;
    if (brgTick && phase_q && (st_q == M_ACK ||
        ((st_q == M_TX || st_q == M_RX) && lastBit)))
      sif_d = 1'b1;
    // (RULE14) take slave acknowledge on ninth clock
    if (st_q == M_TX && bit_q == BITS_PER_BYTE && sclEdgeUp)
      ack_d = sdaIn;
    if (st_q == M_RX && bit_q != BITS_PER_BYTE && sclEdgeUp)
      rx_d = {rx_q[6:0], sdaIn};
    if (st_q == M_RX && lastBit && brgTick && phase_q)
      bf_d = 1'b1;
    // bus condition detection
    if (sclIn && sclPrev_q && sdaPrev_q && !sdaIn)
    begin
      ss_d = 1'b1;
      gc_d = 1'b0;
      ps_d = 1'b0;
      sbit_d = 4'h0;
      addrPhase_d = 1'b1;
    end
    if (sclIn && sclPrev_q && !sdaPrev_q && sdaIn)
    begin
      ps_d = 1'b1;
      ss_d = 1'b0;
      addrPhase_d = 1'b0;
    end
    // slave side address recognition
    if (modeSelect != MODE_MASTER && sclEdgeUp && addrPhase_q)
    begin
      ssh_d = {ssh_q[6:0], sdaIn};
      sbit_d = sbit_q + 4'h1;
      if (sbit_q == 4'h7)
      begin
        addrPhase_d = 1'b0;
        // (RULE3) all zero with write bit
        // (RULE4) own address or general call
        if (gcMatch({ssh_q[6:0], sdaIn}, generalCallEnable))
        begin
          // (RULE5) copy to buffer at eighth bit
          rx_d = {ssh_q[6:0], sdaIn};
          bf_d = 1'b1;
          gc_d = 1'b1;
        end
        else if ({ssh_q[6:0], sdaIn} == addressReload)
        begin
          rx_d = {ssh_q[6:0], sdaIn};
          bf_d = 1'b1;
          gc_d = 1'b0;
          // (RULE6) ten-bit mode asks for new address
          if (modeSelect == MODE_SLAVE10)
            ua_d = 1'b1;
        end
        else
          sbit_d = 4'h9; // no match: no eighth-clock flag
      end
    end
    // (RULE5) flag on falling edge of the eighth clock
    if (modeSelect != MODE_MASTER && sclEdgeDn && sbit_q == 4'h8)
    begin
      sif_d = 1'b1;
      sbit_d = 4'h9;
    end
    if (ua_q && !updateAddressPending())
      ua_d = 1'b0;
    // (RULE1) hold only once line seen low
    if (!clockRelease && !sclIn)
      hold_d = 1'b1;
    // (RULE2) let go as soon as release set
    if (clockRelease && hold_q)
      hold_d = 1'b0;
    // (RULE8) clear on disable
    if (!moduleEnable)
    begin
      ss_d = 1'b0;
      ps_d = 1'b0;
      hold_d = 1'b0;
    end
  end


  // ==========================================================
  // register every group
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_q <= M_IDLE;
      brg_q <= RELOAD_RESET;
      brgRun_q <= 1'b0;
      phase_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= BYTE_RESET;
      step_q <= 2'd0;
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
      rel_q <= 1'b0;
      sif_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ack_q <= 1'b0;
      bf_q <= 1'b0;
      ua_q <= 1'b0;
      gc_q <= 1'b0;
      ss_q <= 1'b0;
      ps_q <= 1'b0;
      rx_q <= BYTE_RESET;
      hold_q <= 1'b0;
      sbit_q <= 4'h0;
      ssh_q <= BYTE_RESET;
      addrPhase_q <= 1'b0;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      addrSeen_q <= BYTE_RESET;
    end
    else
    begin
      st_q <= st_d;
      brg_q <= brg_d;
      brgRun_q <= brgRun_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      step_q <= step_d;
      sclLow_q <= sclLow_d;
      sdaLow_q <= sdaLow_d;
      rel_q <= rel_d;
      sif_q <= sif_d;
      write_collision_flag_q <= write_collision_flag_d;
      ack_q <= ack_d;
      bf_q <= bf_d;
      ua_q <= ua_d;
      gc_q <= gc_d;
      ss_q <= ss_d;
      ps_q <= ps_d;
      rx_q <= rx_d;
      hold_q <= hold_d;
      sbit_q <= sbit_d;
      ssh_q <= ssh_d;
      addrPhase_q <= addrPhase_d;
      sclPrev_q <= sclIn;
      sdaPrev_q <= sdaIn;
      addrSeen_q <= (ua_d && !ua_q) ? addressReload : addrSeen_q;
    end
  end

  // ==========================================================
  // outputs; lines are open drain, output value always low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = sclLow_q || hold_q;
  assign sdaOe  = sdaLow_q;
  assign rxBuffer = rx_q;
  assign bufferFull = bf_q;
  assign ackStatus = ack_q;
  assign serialIntFlag = sif_q;
  assign writeCollision = write_collision_flag_q;
  assign updateAddress = ua_q;
  assign generalCallHit = gc_q;
  assign startSeen = ss_q;
  assign stopSeen = ps_q;
  assign busyStart = (st_q == M_START) || (st_q == M_RST);
endmodule // twi_engine
`default_nettype wire

// ===== tb/twi_slave_model.sv
/*
  Behavioural bus slave: shifts bytes in, acknowledges, may stretch.
  Assumes lines resolved with pull-ups outside.
*/
`timescale 1ns/1ps
`default_nettype none
module twi_slave_model (
  // clock and lines
  input  wire logic       mclk,
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour
  input  wire logic       ackOn,
  input  wire logic       stretch,
  // drive low and last byte
  output logic            sclLow = 1'b0,
  output logic            sdaLow = 1'b0,
  output logic [7:0]      gotByte = 8'h00
);
  logic       sclQ = 1'b1;
  logic       sdaQ = 1'b1;
  logic [3:0] cnt  = 4'h9;
  logic [7:0] sh   = 8'h00;
  int         hold = 0;
  // ==========================================
  // edge detect, shift, ack and stretch
  always @(posedge mclk)
  begin
    sclQ <= scl;
    sdaQ <= sda;
    if (hold > 0) hold <= hold - 1;
    else sclLow <= 1'b0;
    if (!scl && sclQ && stretch && cnt == 4'h4)
    begin
      sclLow <= 1'b1;
      hold   <= 20;
    end
    if (scl && sclQ && sdaQ && !sda) cnt <= 4'h0;
    else if (scl && !sclQ && cnt < 4'h8)
    begin
      sh  <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
    end
    else if (!scl && sclQ && cnt == 4'h8)
    begin
      gotByte <= sh;
      sdaLow  <= ackOn;
      cnt     <= 4'h9;
    end
    else if (!scl && sclQ && cnt == 4'h9)
    begin
      sdaLow <= 1'b0;
      cnt    <= 4'h0;
    end
  end
endmodule // twi_slave_model
`default_nettype wire

// ===== tb/twi_engine_asserts.sv
/*
  Port checker for twi_engine.
  Bound to every twi_engine instance.
*/
`timescale 1ns/1ps
`default_nettype none
module twi_engine_asserts
  import twi_pkg::*;
(
  // watched ports
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       moduleEnable,
  input wire logic [3:0] modeSelect,
  input wire logic [7:0] addressReload,
  input wire logic       clockRelease,
  input wire logic       wcolClear,
  input wire logic       txValid,
  input wire logic       busyStart,
  input wire logic       writeCollision,
  input wire logic       serialIntFlag,
  input wire logic       startSeen,
  input wire logic       stopSeen,
  input wire logic       sclIn,
  input wire logic       sclOe,
  input wire logic       sdaOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic       master;
  logic [7:0] hiCnt_q;
  logic [7:0] hiCnt_d;
  assign master = moduleEnable && (modeSelect == MODE_MASTER);
  // ==========================================
  // cycles since the clock line was let go
  always_comb
  begin
    hiCnt_d = (hiCnt_q == 8'hff) ? hiCnt_q : hiCnt_q + 8'h01;
    if (sclOe) hiCnt_d = 8'h00;
  end
  always_ff @(posedge mclk) hiCnt_q <= !rstn ? 8'hff : hiCnt_d;
  // ==========================================
  // properties
  reset_idle_a: assert property (disable iff (1'b0) !rstn |=> !sclOe && !sdaOe && !startSeen)
    else $error("lines or flags busy after reset");
  disable_clear_a: assert property (!moduleEnable |=> !startSeen && !stopSeen && !sdaOe)
    else $error("seen flags kept while disabled");
  write_collision_flag_set_a: assert property (txValid && busyStart |=> writeCollision)
    else $error("write during start not flagged");
  write_collision_flag_keep_a: assert property (writeCollision && !wcolClear |=> writeCollision)
    else $error("collision flag dropped on its own");
  hold_late_a: assert property (!master && !clockRelease && $rose(sclOe) |-> !$past(sclIn))
    else $error("clock held before line seen low");
  hold_keep_a: assert property (!master && sclOe && !clockRelease |=> sclOe)
    else $error("held clock let go early");
  stretch_wait_a: assert property (master && !sclOe && !sclIn |=> !sclOe)
    else $error("master pulled clock while stretched");
  high_min_a: assert property (master && $rose(sclOe) && hiCnt_q != 8'hff
    |-> hiCnt_q > {1'b0, addressReload[6:0]})
    else $error("clock high time under one rollover");
  start_flag_a: assert property (master && $fell(busyStart) |-> ##[0:2] serialIntFlag)
    else $error("start end without interrupt flag");
endmodule // twi_engine_asserts
bind twi_engine twi_engine_asserts u_twi_engine_asserts (.*);
`default_nettype wire

// ===== tb/twi_engine_tb.sv
/*
  Self-checking bench for twi_engine with a slave model.
  Assumes 20 MHz mclk and pull-ups on both lines.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin nErrors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module twi_engine_tb;
  import twi_pkg::*;
  logic mclk = 0, rstn = 0, moduleEnable = 0, pinDirSclIn = 1, pinDirSdaIn = 1;
  logic [3:0] modeSelect = MODE_MASTER;
  logic [7:0] addressReload = 8'h04, txData = 8'h00, rxBuffer, gotByte; // nonzero while master mode runs
  logic generalCallEnable = 0, clockRelease = 1, ackData = 0, startEnable = 0;
  logic rstartEnable = 0, stopEnable = 0, recvEnable = 0, ackEnable = 0;
  logic intClear = 0, wcolClear = 0, rxRead = 0, txValid = 0, txReady;
  logic bufferFull, ackStatus, serialIntFlag, writeCollision, updateAddress;
  logic generalCallHit, startSeen, stopSeen, busyStart, sclOut, sdaOut;
  logic sclOe, sdaOe, sLowScl, sLowSda, ackOn = 1, stretch = 0;
  logic tbScl0 = 0, tbSda0 = 0;
  wire  sclIn = !(sclOe | sLowScl | tbScl0);
  wire  sdaIn = !(sdaOe | sLowSda | tbSda0);
  int   nErrors = 0, cmpCount = 0;
  logic [7:0] fb [3] = '{8'h00, 8'h00, 8'hf2};
  logic [2:0] fe [3] = '{3'b110, 3'b000, 3'b101};
  always #25 mclk = ~mclk;
  twi_engine u_twi_engine (.*);
  twi_slave_model u_twi_slave_model (.mclk(mclk), .scl(sclIn), .sda(sdaIn), .ackOn(ackOn),
    .stretch(stretch), .sclLow(sLowScl), .sdaLow(sLowSda), .gotByte(gotByte));
  // ==========================================
  // tasks
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge mclk);
  endtask
  task automatic put(input logic [7:0] b);
    txData = b;
    txValid = 1;
    cyc();
    txValid = 0;
  endtask
  task automatic giveVerdict();
    if (nErrors == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic waitFlag();
    int i;
    for (i = 0; i < 3000 && serialIntFlag !== 1'b1; i++) cyc();
    `CHK("flag wait", 1'b1, serialIntFlag)
    if (i == 3000) giveVerdict();
    intClear = 1;
    cyc();
    intClear = 0;
  endtask
  // bit-banged frame: start, byte, ninth clock
  task automatic frame(input logic [7:0] b);
    tbScl0 = 0;
    cyc(4);
    tbSda0 = 1;
    cyc(4);
    for (int k = 7; k >= 0; k--)
    begin
      tbScl0 = 1;
      cyc(2);
      tbSda0 = !b[k];
      cyc(2);
      tbScl0 = 0;
      cyc(4);
    end
    tbScl0 = 1;
    tbSda0 = 0;
    cyc(4);
    tbScl0 = 0;
    cyc(4);
    tbScl0 = 1;
    cyc(4);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    cyc(12);
    rstn = 1;
    cyc();
    `CHK("flags", 3'b000, {serialIntFlag, writeCollision, startSeen})
    `CHK("txReady", 1'b1, txReady)
    moduleEnable = 1;
    cyc(2);
    startEnable = 1;
    cyc();
    startEnable = 0;
    put(8'hff);
    `CHK("write_collision_flag", 1'b1, writeCollision)
    waitFlag();
    `CHK("startSeen", 1'b1, startSeen)
    wcolClear = 1;
    cyc();
    wcolClear = 0;
    `CHK("write_collision_flag clear", 1'b0, writeCollision)
    put(8'ha0);
    waitFlag();
    `CHK("address", 8'ha0, gotByte)
    `CHK("ack", 1'b0, ackStatus)
    ackOn = 0;
    stretch = 1;
    put(8'h5a);
    waitFlag();
    `CHK("data", 8'h5a, gotByte)
    `CHK("nack", 1'b1, ackStatus)
    rstartEnable = 1;
    cyc();
    rstartEnable = 0;
    waitFlag();
    `CHK("bus kept", 1'b1, sdaOe)
    recvEnable = 1;
    cyc();
    recvEnable = 0;
    waitFlag();
    `CHK("rx byte", 9'h1ff, {bufferFull, rxBuffer})
    ackEnable = 1;
    cyc();
    ackEnable = 0;
    `CHK("ack out", 1'b1, sdaOe)
    waitFlag();
    stopEnable = 1;
    cyc();
    stopEnable = 0;
    waitFlag();
    `CHK("stopSeen", 1'b1, stopSeen)
    pinDirSdaIn = 0;
    startEnable = 1;
    cyc(8);
    startEnable = 0;
    `CHK("pin gate", 1'b0, sdaOe)
    pinDirSdaIn = 1;
    moduleEnable = 0;
    cyc(2);
    `CHK("seen off", 2'b00, {startSeen, stopSeen})
    stretch = 0;
    modeSelect = MODE_SLAVE10;
    moduleEnable = 1;
    for (int f = 0; f < 3; f++)
    begin
      generalCallEnable = fe[f][2];
      addressReload = fb[f] ^ {~fe[f][2], 7'h00};
      cyc(2);
      frame(fb[f]);
      `CHK("gc hit", fe[f][1], generalCallHit)
      `CHK("ua", fe[f][0], updateAddress)
      `CHK("rx buf", fb[f], rxBuffer)
      `CHK("bf", fe[f][2], bufferFull)
      `CHK("int", fe[f][2], serialIntFlag)
      clockRelease = 0;
      cyc(4);
      `CHK("hold", 1'b1, sclOe)
      tbScl0 = 0;
      cyc(4);
      `CHK("hold kept", 1'b1, sclOe)
      clockRelease = 1;
      cyc(4);
      `CHK("hold free", 1'b0, sclOe)
      intClear = 1;
      rxRead = 1;
      cyc();
      intClear = 0;
      rxRead = 0;
      tbScl0 = 1;
      cyc(2);
    end
    giveVerdict();
  end
endmodule // twi_engine_tb
`default_nettype wire
